// ===== logic/irq_flag_pkg.sv
// Purpose: shared constants and carriers for the interrupt flag block
// Assumes: one 20 MHz clock, synchronous active-high reset
// Notes: register offsets are word indices on the plain register port
package irq_flag_pkg;
    // ****************************************
    // register map
    // ****************************************
    localparam logic [2:0] ADDR_FLAG = 3'h0;
    localparam logic [2:0] ADDR_ENABLE = 3'h1;
    localparam logic [2:0] ADDR_STATUS = 3'h2;
    localparam logic [2:0] ADDR_TX_STATUS = 3'h3;
    localparam logic [2:0] ADDR_CONTROL = 3'h4;
    localparam logic [2:0] ADDR_RETRY = 3'h5;
    localparam logic [2:0] ADDR_FILTER = 3'h6;
    localparam logic [2:0] ADDR_FRAME_DEC = 3'h7;

    // ****************************************
    // bit positions
    // ****************************************
    localparam int BIT_GLOBAL = 15;
    localparam int BIT_EXPONENT = 14;
    localparam int BIT_DIGEST = 13;
    localparam int BIT_CIPHER = 12;
    localparam int BIT_LINK = 11;
    localparam int BIT_PENDING = 6;
    localparam int BIT_COPY = 5;
    localparam int BIT_RSVD4 = 4;
    localparam int BIT_TX_DONE = 3;
    localparam int BIT_TX_ABORT = 2;
    localparam int BIT_RX_ABORT = 1;
    localparam int BIT_FULL = 0;
    localparam int CTL_EXPONENT_RUN = 15;
    localparam int CTL_CIPHER_RUN = 11;
    localparam int CTL_COPY_RUN = 5;
    localparam int CTL_TX_REQUEST = 1;
    localparam int ST_LINK_UP = 8;
    localparam int TXS_LATE = 10;
    localparam int TXS_DEFER = 8;

    // ****************************************
    // reset values and limits
    // ****************************************
    localparam logic [15:0] ENABLE_RESET = 16'h8010;
    localparam logic [15:0] FLAG_RESET = 16'h0000;
    localparam logic [15:0] FILTER_RESET = 16'h0000;
    localparam logic [3:0] RETRY_RESET = 4'hf;
    localparam logic [7:0] COUNT_FULL = 8'hff;
    localparam logic [6:0] LATE_BYTES = 7'h3f;
    localparam logic [15:0] ENABLE_WMASK = 16'hf86f;

    // events arriving from the engines, MAC and PHY
    typedef struct packed {
        logic exponentDone;
        logic digestDone;
        logic cipherDone;
        logic copyDone;
        logic txDone;
        logic collision;
        logic [6:0] bytesSent;
        logic deferAbort;
        logic frameArrived;
        logic frameAccepted;
        logic bufferOverrun;
    } engine_events_s;

    typedef struct packed {
        logic [2:0] addr;
        logic [15:0] wdata;
        logic wr;
        logic rd;
    } reg_req_s;
endpackage

// ===== logic/ethernet_irq_flag_logic.sv
// Purpose: interrupt flags, enables and the active-low interrupt pin
// Assumes: engine events are one-cycle pulses on sys_clk; link pin async
// Notes: flag register clears by writing one to the bit (write-one-clear)
`timescale 1ns/1ns
`default_nettype none
module ethernet_irq_flag_logic
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire irq_flag_pkg::reg_req_s regReq,
    output logic [15:0] regRdata,
    input wire irq_flag_pkg::engine_events_s events,
    input wire logic linkPin,
    output logic txStart,
    output logic frameDrop,
    output logic irqPin_n
);
    import irq_flag_pkg::*;

    // ****************************************
    // state
    // ****************************************
    logic [15:0] flag_reg;
    logic [15:0] enable_reg;
    logic [15:0] control_reg;
    logic [15:0] filter_reg;
    logic [3:0] retry_reg;
    logic [3:0] collisionCount_reg;
    logic lateCollision_reg;
    logic excessDefer_reg;
    logic [7:0] frameCount_reg;
    logic [1:0] linkSync_reg;
    logic linkUp_reg;
    logic txActive_reg;

    // next values, decodes and gates
    logic [15:0] flag_next;
    logic [15:0] control_next;
    logic [15:0] setMask;
    logic wrFlag;
    logic wrCtl;
    logic dec;
    logic countFull;
    logic frameOk;
    logic collAbort;
    logic lateAbort;
    logic txAbort;
    logic swAbort;
    logic linkEdge;
    logic wrEnable;
    logic wrRetry;
    logic wrFilter;
    logic decOk;
    logic txEnd;
    logic [15:0] flagView;
    logic [15:0] armed;
    logic [15:0] readMux;

    // ****************************************
    // register port decodes
    // ****************************************
    assign wrFlag = regReq.wr && regReq.addr == ADDR_FLAG;
    assign wrCtl = regReq.wr && regReq.addr == ADDR_CONTROL;
    assign dec = regReq.wr && regReq.addr == ADDR_FRAME_DEC;
    assign countFull = frameCount_reg == COUNT_FULL;
    assign linkEdge = linkSync_reg[1] != linkUp_reg;
    assign wrEnable = regReq.wr && regReq.addr == ADDR_ENABLE;
    assign wrRetry = regReq.wr && regReq.addr == ADDR_RETRY;
    assign wrFilter = regReq.wr && regReq.addr == ADDR_FILTER;
    assign decOk = dec && frameCount_reg != 8'h00;
    assign txEnd = txActive_reg && (events.txDone || txAbort);

    // ****************************************
    // link pin synchroniser
    // ****************************************
    // only the second stage feeds logic; the first may be metastable
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            linkSync_reg <= 2'h0;
        else
            linkSync_reg <= {linkSync_reg[0], linkPin};
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            linkUp_reg <= 1'b0;
        else
            linkUp_reg <= linkSync_reg[1];
    end

    // ****************************************
    // transmit outcome
    // ****************************************
    // collisions beyond the retry limit, or a late one, end the frame
    always_comb
    begin
        lateAbort = events.collision && events.bytesSent > LATE_BYTES;
        collAbort = events.collision && !lateAbort
                    && collisionCount_reg >= retry_reg;
        swAbort = wrCtl && txActive_reg
                  && !regReq.wdata[CTL_TX_REQUEST];
        txAbort = txActive_reg
                  && (collAbort || lateAbort || events.deferAbort);
    end

    // a start only from an idle request bit, so a rewrite never restarts
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
        begin
            txActive_reg <= 1'b0;
            txStart <= 1'b0;
        end
        else
        begin
            txStart <= wrCtl && !control_reg[CTL_TX_REQUEST]
                       && regReq.wdata[CTL_TX_REQUEST];
            txActive_reg <= control_next[CTL_TX_REQUEST];
        end
    end

    // the aborting collision is not counted, so the count cannot wrap
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || txStart)
            collisionCount_reg <= 4'h0;
        else if (txActive_reg && events.collision && !lateAbort
                 && !collAbort)
            collisionCount_reg <= collisionCount_reg + 4'h1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || txStart)
            lateCollision_reg <= 1'b0;
        else if (txActive_reg && lateAbort)
            lateCollision_reg <= 1'b1;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || txStart)
            excessDefer_reg <= 1'b0;
        else if (txActive_reg && events.deferAbort)
            excessDefer_reg <= 1'b1;
    end

    // ****************************************
    // control register; hardware clears run bits
    // ****************************************
    always_comb
    begin
        // a done event in the cycle of a write still clears its run bit
        control_next = control_reg;
        if (wrCtl)
            control_next = regReq.wdata;
        if (events.exponentDone)
            control_next[CTL_EXPONENT_RUN] = 1'b0;
        if (events.cipherDone)
            control_next[CTL_CIPHER_RUN] = 1'b0;
        if (events.copyDone)
            control_next[CTL_COPY_RUN] = 1'b0;
        if (txEnd)
            control_next[CTL_TX_REQUEST] = 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            control_reg <= 16'h0000;
        else
            control_reg <= control_next;
    end

    // ****************************************
    // frame counter
    // ****************************************
    // filter-rejected frames never assert frameAccepted, so no abort
    assign frameOk = events.frameAccepted && !events.bufferOverrun
                     && !countFull;

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            frameDrop <= 1'b0;
        else
            frameDrop <= events.frameAccepted && !frameOk;
    end

    // accept and decrement in one cycle leave the count as it is
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            frameCount_reg <= 8'h00;
        else if (frameOk && !decOk)
            frameCount_reg <= frameCount_reg + 8'h01;
        else if (!frameOk && decOk)
            frameCount_reg <= frameCount_reg - 8'h01;
    end

    // ****************************************
    // sticky flags: set wins over clear
    // ****************************************
    always_comb
    begin
        setMask = 16'h0000;
        setMask[BIT_EXPONENT] = control_reg[CTL_EXPONENT_RUN]
                                && !control_next[CTL_EXPONENT_RUN];
        setMask[BIT_DIGEST] = events.digestDone;
        setMask[BIT_CIPHER] = control_reg[CTL_CIPHER_RUN]
                              && !control_next[CTL_CIPHER_RUN];
        setMask[BIT_LINK] = linkEdge;
        setMask[BIT_COPY] = control_reg[CTL_COPY_RUN]
                            && !control_next[CTL_COPY_RUN];
        setMask[BIT_TX_DONE] = control_reg[CTL_TX_REQUEST]
                               && !control_next[CTL_TX_REQUEST];
        setMask[BIT_TX_ABORT] = txAbort || swAbort;
        setMask[BIT_RX_ABORT] = events.frameAccepted && !frameOk;
    end

    always_comb
    begin
        // software clear first, so an event in the same cycle wins
        flag_next = flag_reg;
        if (wrFlag)
            flag_next = flag_reg & ~regReq.wdata;
        flag_next = flag_next | setMask;
        flag_next[BIT_PENDING] = 1'b0;
        flag_next[BIT_FULL] = 1'b0;
        flag_next[BIT_RSVD4] = 1'b0;
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            flag_reg <= FLAG_RESET;
        else
            flag_reg <= flag_next;
    end

    // ****************************************
    // enable, retry limit and filter settings
    // ****************************************
    // reserved bit 4 reads one and ignores writes
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            enable_reg <= ENABLE_RESET;
        else if (wrEnable)
            enable_reg <= (regReq.wdata & ENABLE_WMASK)
                          | (ENABLE_RESET & ~ENABLE_WMASK);
    end

    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            retry_reg <= RETRY_RESET;
        else if (wrRetry)
            retry_reg <= regReq.wdata[3:0];
    end

    // wake arming is software's job; bits only stored here
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            filter_reg <= FILTER_RESET;
        else if (wrFilter)
            filter_reg <= regReq.wdata;
    end

    // ****************************************
    // read port and interrupt pin
    // ****************************************
    always_comb
    begin
        flagView = flag_reg;
        flagView[BIT_PENDING] = frameCount_reg != 8'h00;
        flagView[BIT_FULL] = countFull;
    end

    // the global bit is a gate, not a source, so it is masked out
    assign armed = flagView & enable_reg & ~(16'h0001 << BIT_GLOBAL);

    // pin is registered so the host never sees a combinational glitch
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            irqPin_n <= 1'b1;
        else
            irqPin_n <= !(enable_reg[BIT_GLOBAL]
                          && |armed);
    end

    always_comb
    begin
        case (regReq.addr)
            ADDR_FLAG: readMux = flagView;
            ADDR_ENABLE: readMux = enable_reg;
            ADDR_STATUS: readMux = {7'h00, linkUp_reg, frameCount_reg};
            ADDR_TX_STATUS: readMux = {5'h00, lateCollision_reg, 1'b0,
                                       excessDefer_reg, 4'h0,
                                       collisionCount_reg};
            ADDR_CONTROL: readMux = control_reg;
            ADDR_RETRY: readMux = {12'h000, retry_reg};
            ADDR_FILTER: readMux = filter_reg;
            default: readMux = 16'h0000;
        endcase
    end

    // read data stands in each cycle after a cycle with rd high, and reads zero otherwise
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst || !regReq.rd)
            regRdata <= 16'h0000;
        else
            regRdata <= readMux;
    end
endmodule // ethernet_irq_flag_logic
`default_nettype wire

// ===== test/irq_flag_asserts.sv
// Purpose: port checks for the interrupt flag block
// Assumes: single sys_clk domain, sync reset
// Notes: enable register mirrored from port writes
`timescale 1ns/1ns
`default_nettype none
module irq_flag_asserts
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire irq_flag_pkg::reg_req_s regReq,
    input wire logic [15:0] regRdata,
    input wire irq_flag_pkg::engine_events_s events,
    input wire logic txStart,
    input wire logic frameDrop,
    input wire logic irqPin_n
);
    import irq_flag_pkg::*;
    logic [15:0] enMirror_reg;
    logic enRead_reg;
    logic txSet_reg;
    always_ff @(posedge sys_clk)
    begin
        if (sys_rst)
            enMirror_reg <= ENABLE_RESET;
        else if (regReq.wr && regReq.addr == ADDR_ENABLE)
            enMirror_reg <= (regReq.wdata & ENABLE_WMASK) | 16'h0010;
    end
    always_ff @(posedge sys_clk)
    begin
        enRead_reg <= !sys_rst && regReq.rd && regReq.addr == ADDR_ENABLE;
        txSet_reg <= regReq.wr && regReq.addr == ADDR_CONTROL
            && regReq.wdata[CTL_TX_REQUEST];
    end
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);
    a_global_gate: assert property (!enMirror_reg[15] |=> irqPin_n)
        else $error("pin low with global enable off");
    a_quiet_pin: assert property (
        (enMirror_reg & 16'h786f) == 16'h0000 |=> irqPin_n)
        else $error("pin low with no source enabled");
    a_digest_pin: assert property (events.digestDone && !regReq.wr
        && enMirror_reg[15] && enMirror_reg[13] |-> ##2 !irqPin_n)
        else $error("digest done did not drive pin");
    a_abort_pin: assert property (events.frameAccepted
        && events.bufferOverrun && !regReq.wr && enMirror_reg[15]
        && enMirror_reg[1] |-> ##2 !irqPin_n)
        else $error("receive abort did not drive pin");
    a_overrun_drop: assert property (events.frameAccepted
        && events.bufferOverrun |=> frameDrop)
        else $error("overrun frame not dropped");
    a_filter_quiet: assert property (!events.frameAccepted
        |=> !frameDrop) else $error("drop without accepted frame");
    a_tx_cause: assert property (txStart |-> txSet_reg)
        else $error("transmit start without request write");
    a_enable_read: assert property (enRead_reg
        |-> regRdata == enMirror_reg) else $error("enable read mismatch");
endmodule // irq_flag_asserts
bind ethernet_irq_flag_logic irq_flag_asserts chk
(
    .sys_clk(sys_clk),
    .sys_rst(sys_rst),
    .regReq(regReq),
    .regRdata(regRdata),
    .events(events),
    .txStart(txStart),
    .frameDrop(frameDrop),
    .irqPin_n(irqPin_n)
);
`default_nettype wire

// ===== test/host_wake_model.sv
// Purpose: host side that wakes on the interrupt pin
// Assumes: pin sampled on sys_clk
// Notes: counts falling edges only, a held level counts once
`timescale 1ns/1ns
`default_nettype none
module host_wake_model
(
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic irqPin_n,
    output logic [7:0] wakeCount
);
    logic pinPrev_reg;
    always_ff @(posedge sys_clk)
    begin
        pinPrev_reg <= sys_rst | irqPin_n;
        if (sys_rst)
            wakeCount <= 8'h00;
        else if (pinPrev_reg && !irqPin_n)
            wakeCount <= wakeCount + 8'h01;
    end
endmodule // host_wake_model
`default_nettype wire

// ===== test/test_ethernet_irq_flag_logic.sv
// Purpose: directed bench for the interrupt flag block
// Assumes: 50 ns clock, reset held 4 cycles
// Notes: events are cast from 17-bit vectors, msb exponentDone
`timescale 1ns/1ns
`default_nettype none
module test_ethernet_irq_flag_logic;
    import irq_flag_pkg::*;
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    reg_req_s regReq = '0;
    engine_events_s events = '0;
    logic linkPin = 1'b0;
    logic [15:0] regRdata, rdv;
    logic txStart, frameDrop, irqPin_n;
    logic [7:0] wakeCount;
    int miscompares = 0;
    int compares = 0;
    always #25 sys_clk = ~sys_clk;
    ethernet_irq_flag_logic uut (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .regReq(regReq), .regRdata(regRdata), .events(events),
        .linkPin(linkPin), .txStart(txStart), .frameDrop(frameDrop),
        .irqPin_n(irqPin_n));
    host_wake_model host (.sys_clk(sys_clk), .sys_rst(sys_rst),
        .irqPin_n(irqPin_n), .wakeCount(wakeCount));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        compares++;
        if (got !== exp)
        begin
            miscompares++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk);
        #1;
    endtask
    task automatic wr(input logic [2:0] a, input logic [15:0] d);
        @(posedge sys_clk);
        regReq <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
        @(posedge sys_clk);
        regReq.wr <= 1'b0;
    endtask
    task automatic rdr(input logic [2:0] a);
        @(posedge sys_clk);
        regReq.addr <= a;
        regReq.rd <= 1'b1;
        @(posedge sys_clk);
        regReq.rd <= 1'b0;
        #1;
        rdv = regRdata;
    endtask
    task automatic rdc(input logic [2:0] a, input logic [15:0] m,
        input logic [15:0] e);
        rdr(a);
        check(rdv & m, e);
    endtask
    task automatic pulse(input logic [16:0] v);
        @(posedge sys_clk);
        events <= engine_events_s'(v);
        @(posedge sys_clk);
        events <= '0;
    endtask
    task automatic test_reset();
        rdc(ADDR_ENABLE, 16'hffff, ENABLE_RESET);
        rdc(ADDR_FLAG, 16'hffff, FLAG_RESET);
        check({15'h0, irqPin_n}, 16'h1);
        wr(ADDR_ENABLE, 16'hffff);
        rdc(ADDR_ENABLE, 16'hffff, 16'hf87f);
        wr(ADDR_STATUS, 16'hffff);
        rdc(ADDR_STATUS, 16'h00ff, 16'h0000);
        wr(ADDR_ENABLE, 16'h0000);
    endtask
    task automatic test_engines();
        logic [15:0] run [4] = '{16'h8000, 16'h0000, 16'h0800, 16'h0020};
        logic [15:0] fl [4] = '{16'h4000, 16'h2000, 16'h1000, 16'h0020};
        for (int i = 0; i < 4; i++)
        begin
            wr(ADDR_CONTROL, run[i]);
            wr(ADDR_ENABLE, fl[i]);
            pulse(17'h10000 >> i);
            tick(3);
            check({15'h0, irqPin_n}, 16'h1);
            rdc(ADDR_FLAG, 16'hffff, fl[i]);
            wr(ADDR_ENABLE, fl[i] | 16'h8000);
            tick(3);
            check({15'h0, irqPin_n}, 16'h0);
            rdc(ADDR_FLAG, 16'hffff, fl[i]);
            wr(ADDR_FLAG, fl[i]);
            tick(3);
            check({15'h0, irqPin_n}, 16'h1);
            wr(ADDR_CONTROL, run[i]);
            pulse(17'h10000 >> i);
            tick(2);
            check({15'h0, irqPin_n}, 16'h0);
            wr(ADDR_FLAG, fl[i]);
        end
    endtask
    task automatic test_tx();
        logic [16:0] ev [3] = '{17'h01000, 17'h00c00, 17'h00008};
        logic [15:0] fl [3] = '{16'h0008, 16'h000c, 16'h000c};
        logic [15:0] st [3] = '{16'h0000, 16'h0400, 16'h0100};
        wr(ADDR_ENABLE, 16'h800c);
        for (int i = 0; i < 3; i++)
        begin
            wr(ADDR_CONTROL, 16'h0002);
            #1;
            check({15'h0, txStart}, 16'h1);
            pulse(ev[i]);
            tick(3);
            check({15'h0, irqPin_n}, 16'h0);
            rdc(ADDR_FLAG, 16'h000c, fl[i]);
            rdc(ADDR_TX_STATUS, 16'h0500, st[i]);
            rdc(ADDR_CONTROL, 16'h0002, 16'h0000);
            wr(ADDR_FLAG, 16'h000c);
        end
        wr(ADDR_CONTROL, 16'h0002);
        wr(ADDR_CONTROL, 16'h0000);
        rdc(ADDR_FLAG, 16'h000c, 16'h000c);
        wr(ADDR_FLAG, 16'h000c);
        wr(ADDR_RETRY, 16'h0001);
        wr(ADDR_CONTROL, 16'h0002);
        pulse(17'h00850);
        rdc(ADDR_FLAG, 16'h000c, 16'h0000);
        pulse(17'h00850);
        rdc(ADDR_FLAG, 16'h0004, 16'h0004);
        rdc(ADDR_TX_STATUS, 16'h000f, 16'h0001);
        wr(ADDR_FLAG, 16'h000c);
    endtask
    task automatic test_rx();
        logic [7:0] wakeBase;
        wakeBase = wakeCount;
        wr(ADDR_FILTER, 16'h4050);
        rdc(ADDR_FILTER, 16'hffff, 16'h4050);
        rdc(ADDR_STATUS, 16'h00ff, 16'h0000);
        wr(ADDR_ENABLE, 16'h8043);
        pulse(17'h00002);
        tick(2);
        check({15'h0, irqPin_n}, 16'h0);
        check({8'h0, wakeCount - wakeBase}, 16'h0001);
        rdc(ADDR_STATUS, 16'h00ff, 16'h0001);
        wr(ADDR_FLAG, 16'h0040);
        rdc(ADDR_FLAG, 16'h0040, 16'h0040);
        pulse(17'h00003);
        #1;
        check({15'h0, frameDrop}, 16'h1);
        rdc(ADDR_FLAG, 16'h0002, 16'h0002);
        wr(ADDR_FLAG, 16'h0002);
        pulse(17'h00004);
        rdc(ADDR_FLAG, 16'h0002, 16'h0000);
        wr(ADDR_FRAME_DEC, 16'h0000);
        rdc(ADDR_FLAG, 16'h0040, 16'h0000);
        repeat (255) pulse(17'h00002);
        rdc(ADDR_STATUS, 16'h00ff, {8'h00, COUNT_FULL});
        rdc(ADDR_FLAG, 16'h0003, 16'h0001);
        pulse(17'h00002);
        #1;
        check({15'h0, frameDrop}, 16'h1);
        rdc(ADDR_FLAG, 16'h0002, 16'h0002);
        wr(ADDR_FRAME_DEC, 16'h0000);
        rdc(ADDR_FLAG, 16'h0001, 16'h0000);
        rdc(ADDR_STATUS, 16'h00ff, 16'h00fe);
    endtask
    task automatic test_link();
        int n;
        wr(ADDR_ENABLE, 16'h8800);
        wr(ADDR_FLAG, 16'hffff);
        linkPin <= 1'b1;
        rdv = '0;
        for (n = 0; n < 8 && rdv[ST_LINK_UP] !== 1'b1; n++)
            rdr(ADDR_STATUS);
        if (rdv[ST_LINK_UP] !== 1'b1)
        begin
            miscompares++;
            print_verdict();
        end
        rdc(ADDR_FLAG, 16'h0800, 16'h0800);
        wr(ADDR_FLAG, 16'h0800);
        linkPin <= 1'b0;
        tick(8);
        rdc(ADDR_STATUS, 16'h0100, 16'h0000);
        rdc(ADDR_FLAG, 16'h0800, 16'h0800);
    endtask
    task automatic print_verdict();
        $display("compares %0d miscompares %0d", compares, miscompares);
        if (miscompares == 0 && compares > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    initial
    begin
        repeat (4) @(posedge sys_clk);
        sys_rst <= 1'b0;
        test_reset();
        $display("reset test done");
        test_engines();
        $display("engine test done");
        test_tx();
        $display("transmit test done");
        test_rx();
        $display("receive test done");
        test_link();
        $display("link test done");
        print_verdict();
    end
endmodule // test_ethernet_irq_flag_logic
`default_nettype wire
